// [shared/sci_defines.vh]
// register map, field layout and timing constants for the soft command input bank
`ifndef SCI_DEFINES_VH
`define SCI_DEFINES_VH

// register word addresses (avalon word address, byte address = 4 * index)
`define SCI_ADDR_W          3
`define SCI_REG_STATE       3'h0
`define SCI_REG_MODE        3'h1
`define SCI_REG_QUICK_EN    3'h2
`define SCI_REG_SET         3'h3
`define SCI_REG_CLR         3'h4
`define SCI_REG_QUICK_CMD   3'h5
`define SCI_REG_STATUS      3'h6

// reset values
`define SCI_MODE_RST        32'h0000_0000
`define SCI_QUICK_EN_RST    32'hffff_ffff

// quick command field layout: [4:0] input index, [6:5] opcode
`define SCI_QC_IDX_HI       4
`define SCI_QC_IDX_LO       0
`define SCI_QC_OP_HI        6
`define SCI_QC_OP_LO        5
`define SCI_QC_OP_NONE      2'h0
`define SCI_QC_OP_SET       2'h1
`define SCI_QC_OP_RESET     2'h2
`define SCI_QC_OP_PULSE     2'h3

// status bits
`define SCI_ST_RESTORED     0
`define SCI_ST_BATT_OK      1
`define SCI_ST_SUPPLY_OK    2

// pulse timing: 10 ms at 40 mhz
`define SCI_PULSE_MS        10
`define SCI_CLK_KHZ         40000
`define SCI_PULSE_CYC       (`SCI_PULSE_MS * `SCI_CLK_KHZ)
`define SCI_TMR_W           19

`endif

// [hw/sci_pulse_timer.v]
// one retriggerable 10 ms pulse timer per command input
`timescale 1ns/1ps

module sci_pulse_timer #(
    parameter PULSE_CYC = 400000
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // control
    input  wire        start,
    input  wire        stop,
    // status
    output reg         active_r
);

`include "sci_defines.vh"

    reg  [`SCI_TMR_W-1:0] count_r;

    // ====================================================================
    // countdown
    // start reloads even when running so a repeated set extends the pulse
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_r  <= {`SCI_TMR_W{1'b0}};
            active_r <= 1'b0;
        end else if (stop) begin
            count_r  <= {`SCI_TMR_W{1'b0}};
            active_r <= 1'b0;
        end else if (start) begin
            count_r  <= PULSE_CYC[`SCI_TMR_W-1:0] - 1'b1;
            active_r <= 1'b1;
        end else if (active_r) begin
            if (count_r == {`SCI_TMR_W{1'b0}}) begin
                active_r <= 1'b0;
            end else begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // sci_pulse_timer

// [hw/sci_command_bank.v]
// soft command input bank: 32 latched or pulsed software switches with retention
`timescale 1ns/1ps
// How it works
// - each of 32 inputs has a mode bit: 0 latched, 1 pulsed.
// - a latched input stays set until a reset command arrives.
// - a pulsed input asserts on set, holds 10 ms, then clears itself.
// - a quick-menu enable mask bit of one makes that input quick-reachable.
// - enabled inputs take quick set, reset or pulse like main commands.
// - on supply failure latched states are captured in backed storage.
// - on supply return retained inputs resume their pre-failure state.
// - with battery absent or flat on supply return all inputs clear.
// - the state word reads one input per bit; writes set ones, reset zeros.
// - each input drives its own scheme-logic output, asserted as one.

module sci_command_bank (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // avalon-mm slave
    input  wire [2:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // supply and battery monitors (asynchronous pins)
    input  wire        supply_ok,
    input  wire        battery_ok,
    // battery-backed storage image
    input  wire [31:0] backup_rd_data,
    output reg  [31:0] backup_wr_data,
    output reg         backup_wr_en,
    // scheme logic outputs
    output reg  [31:0] cmd_out
);

`include "sci_defines.vh"

    reg  [31:0] state_r;
    reg  [31:0] mode_r;
    reg  [31:0] quick_en_r;
    reg         restored_r;
    reg         supply_meta_r;
    reg         supply_r;
    reg         supply_d_r;
    reg         batt_meta_r;
    reg         batt_r;
    reg         ack_r;
    reg  [31:0] set_req;
    reg  [31:0] clr_req;
    wire [31:0] pulse_act;
    wire        bus_req;
    wire        wr_hit;
    wire [4:0]  qc_idx;
    wire [1:0]  qc_op;
    wire        qc_ok;
    wire [31:0] qc_bit;

    // ====================================================================
    // pin synchronisers
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            supply_meta_r <= 1'b0;
            supply_r      <= 1'b0;
            supply_d_r    <= 1'b0;
            batt_meta_r   <= 1'b0;
            batt_r        <= 1'b0;
        end else begin
            supply_meta_r <= supply_ok;
            supply_r      <= supply_meta_r;
            supply_d_r    <= supply_r;
            batt_meta_r   <= battery_ok;
            batt_r        <= batt_meta_r;
        end
    end

    // ====================================================================
    // bus handshake: every access waits exactly one cycle, then acks
    assign bus_req = (avs_read | avs_write) & ~ack_r;
    assign wr_hit  = avs_write & ack_r;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_r           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack_r           <= bus_req;
            avs_waitrequest <= ~bus_req;
        end
    end

    // ====================================================================
    // command decode from main menu (state, set, clear words) and quick menu
    assign qc_idx = avs_writedata[`SCI_QC_IDX_HI:`SCI_QC_IDX_LO];
    assign qc_op  = avs_writedata[`SCI_QC_OP_HI:`SCI_QC_OP_LO];
    assign qc_ok  = wr_hit && (avs_address == `SCI_REG_QUICK_CMD) && quick_en_r[qc_idx];
    assign qc_bit = 32'h0000_0001 << qc_idx;

    always @* begin
        set_req = 32'h0000_0000;
        clr_req = 32'h0000_0000;
        if (wr_hit) begin
            case (avs_address)
                `SCI_REG_STATE: begin
                    set_req = avs_writedata;
                    clr_req = ~avs_writedata;
                end
                `SCI_REG_SET: begin
                    set_req = avs_writedata;
                end
                `SCI_REG_CLR: begin
                    clr_req = avs_writedata;
                end
                default: begin
                    set_req = 32'h0000_0000;
                end
            endcase
        end
        // quick menu acts like the main menu; pulse behaves as set
        if (qc_ok) begin
            if (qc_op == `SCI_QC_OP_SET || qc_op == `SCI_QC_OP_PULSE) begin
                set_req = set_req | qc_bit;
            end else if (qc_op == `SCI_QC_OP_RESET) begin
                clr_req = clr_req | qc_bit;
            end
        end
    end

    // ====================================================================
    // pulse timers, one per input
    // pulses are not retained: they stop while unrestored, so a dip clears them
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_pulse
            sci_pulse_timer #(
                .PULSE_CYC (`SCI_PULSE_CYC)
            ) u_tmr (
                .clk_sys  (clk_sys),
                .rstn     (rstn),
                .start    (set_req[gi] & mode_r[gi] & restored_r),
                .stop     (clr_req[gi] | ~mode_r[gi] | ~restored_r),
                .active_r (pulse_act[gi])
            );
        end
    endgenerate

    // ====================================================================
    // configuration registers
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_r     <= `SCI_MODE_RST;
            quick_en_r <= `SCI_QUICK_EN_RST;
        end else if (wr_hit) begin
            if (avs_address == `SCI_REG_MODE) begin
                mode_r <= avs_writedata;
            end
            if (avs_address == `SCI_REG_QUICK_EN) begin
                quick_en_r <= avs_writedata;
            end
        end
    end

    // ====================================================================
    // latched state and power-return restore
    // commands are ignored until restore has happened, so a stale image
    // cannot be overwritten by an early command
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r    <= 32'h0000_0000;
            restored_r <= 1'b0;
        end else if (supply_r && !supply_d_r) begin
            restored_r <= 1'b1;
            if (batt_r) begin
                state_r <= backup_rd_data & ~mode_r;
            end else begin
                state_r <= 32'h0000_0000;
            end
        end else if (!supply_r) begin
            restored_r <= 1'b0;
        end else if (restored_r) begin
            state_r <= (state_r | (set_req & ~mode_r)) & ~(clr_req | mode_r);
        end
    end

    // ====================================================================
    // backup image: refreshed while supplied, frozen on failure
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            backup_wr_data <= 32'h0000_0000;
            backup_wr_en   <= 1'b0;
        end else begin
            backup_wr_data <= state_r & ~mode_r;
            backup_wr_en   <= supply_r & restored_r;
        end
    end

    // ====================================================================
    // scheme logic outputs
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmd_out <= 32'h0000_0000;
        end else begin
            cmd_out <= state_r | pulse_act;
        end
    end

    // ====================================================================
    // read data, registered on the request cycle
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_req && avs_read) begin
            case (avs_address)
                `SCI_REG_STATE:    avs_readdata <= state_r | pulse_act;
                `SCI_REG_MODE:     avs_readdata <= mode_r;
                `SCI_REG_QUICK_EN: avs_readdata <= quick_en_r;
                `SCI_REG_STATUS: begin
                    avs_readdata <= 32'h0000_0000;
                    avs_readdata[`SCI_ST_RESTORED]  <= restored_r;
                    avs_readdata[`SCI_ST_BATT_OK]   <= batt_r;
                    avs_readdata[`SCI_ST_SUPPLY_OK] <= supply_r;
                end
                default:           avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // sci_command_bank

// [verification/sci_backup_store.sv]
// battery-backed storage model facing the command bank
`timescale 1ns/1ps
module sci_backup_store #(
    parameter [31:0] INIT_IMAGE = 32'h5a5a_a5a5
) (
    // clock
    input  wire        clk_sys,
    // battery and image
    input  wire        battery_ok,
    input  wire [31:0] backup_wr_data,
    input  wire        backup_wr_en,
    output wire [31:0] backup_rd_data
);
    // ========
    // storage cell
    reg [31:0] mem_r = INIT_IMAGE;
    // a flat battery loses the image, so it churns rather than holding stale data
    always @(posedge clk_sys) begin
        if (!battery_ok)
            mem_r <= ~mem_r;
        else if (backup_wr_en)
            mem_r <= backup_wr_data;
    end
    assign backup_rd_data = mem_r;
endmodule // sci_backup_store

// [verification/sci_command_bank_props.sv]
// port checker for the soft command input bank
`timescale 1ns/1ps
`include "sci_defines.vh"
module sci_command_bank_props (
    // clock and reset
    input wire        clk_sys,
    input wire        rstn,
    // bus and pins
    input wire [2:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        supply_ok,
    input wire        backup_wr_en,
    input wire [31:0] cmd_out
);
    // ========
    // accepted write strobe
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire wr = avs_write & ~avs_waitrequest;
    chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");
    chk_wait_bound: assert property ((avs_read | avs_write) |-> ##[0:2] !avs_waitrequest)
        else $error("request not answered");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 3'h7 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_state_word: assert property (wr && avs_address == `SCI_REG_STATE && backup_wr_en
        |-> ##2 cmd_out == $past(avs_writedata, 2))
        else $error("state word write wrong");
    chk_set_bits: assert property (wr && avs_address == `SCI_REG_SET && backup_wr_en
        |-> ##2 (cmd_out & $past(avs_writedata, 2)) == $past(avs_writedata, 2))
        else $error("set bits not asserted");
    chk_clr_bits: assert property (wr && avs_address == `SCI_REG_CLR && backup_wr_en
        |-> ##2 (cmd_out & $past(avs_writedata, 2)) == 32'h0)
        else $error("cleared bits still high");
    chk_rise_cause: assert property ((|(cmd_out & ~$past(cmd_out))) && $past(backup_wr_en, 3) |-> $past(wr, 2))
        else $error("output rose without a command");
    chk_supply_loss: assert property (!supply_ok [*4] |-> !backup_wr_en)
        else $error("storage written without supply");
endmodule // sci_command_bank_props
bind sci_command_bank sci_command_bank_props i_props (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .supply_ok(supply_ok),
    .backup_wr_en(backup_wr_en), .cmd_out(cmd_out));

// [verification/test_sci_command_bank.sv]
// self-checking testbench for the soft command input bank
`timescale 1ns/1ps
`include "sci_defines.vh"
module test_sci_command_bank;
    // ========
    // stimulus and wiring
    reg          clk_sys = 1'b0;
    reg          rstn = 1'b0;
    reg  [2:0]   avs_address = 3'h0;
    reg          avs_read = 1'b0;
    reg          avs_write = 1'b0;
    reg  [31:0]  avs_writedata = 32'h0;
    reg          supply_ok = 1'b0;
    reg          battery_ok = 1'b0;
    wire [31:0]  avs_readdata, backup_rd_data, backup_wr_data, cmd_out;
    wire         avs_waitrequest, backup_wr_en;
    int          num_errors = 0;
    int          num_checks = 0;
    logic [31:0] expq[$];
    logic [31:0] st;
    always #12.5 clk_sys = ~clk_sys;
    sci_command_bank i_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .supply_ok(supply_ok), .battery_ok(battery_ok),
        .backup_rd_data(backup_rd_data), .backup_wr_data(backup_wr_data), .backup_wr_en(backup_wr_en),
        .cmd_out(cmd_out));
    sci_backup_store i_store (.clk_sys(clk_sys), .battery_ok(battery_ok), .backup_wr_data(backup_wr_data),
        .backup_wr_en(backup_wr_en), .backup_rd_data(backup_rd_data));
    // ========
    // helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // reads queue their expected word; d doubles as expectation
    task bus(input logic [2:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        if (!w) expq.push_back(d);
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // supply dip; battery level is changed only while unpowered
    task power(input logic batt);
        supply_ok <= 1'b0;
        repeat (10) @(posedge clk_sys);
        battery_ok <= batt;
        repeat (4) @(posedge clk_sys);
        supply_ok <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    task test_done;
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // read data compared against the oldest queued note
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            check(avs_readdata, expq.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        test_done;
    end
    // ========
    // main sequence
    initial begin
        st = $urandom(71901);
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        power(1'b0);
        bus(`SCI_REG_STATE, 1'b0, 32'h0);
        // battery comes good while supplied so the store keeps a live image
        battery_ok <= 1'b1;
        bus(3'h7, 1'b0, 32'h0);
        bus(`SCI_REG_QUICK_EN, 1'b0, 32'hffff_ffff);
        bus(`SCI_REG_MODE, 1'b1, 32'h0000_ffff);
        bus(`SCI_REG_MODE, 1'b0, 32'h0000_ffff);
        st = (32'h1 << `SCI_ST_RESTORED) | (32'h1 << `SCI_ST_BATT_OK) | (32'h1 << `SCI_ST_SUPPLY_OK);
        bus(`SCI_REG_STATUS, 1'b0, st);
        st = $urandom;
        bus(`SCI_REG_STATE, 1'b1, st);
        bus(`SCI_REG_STATE, 1'b0, st);
        check(cmd_out, st);
        bus(`SCI_REG_CLR, 1'b1, 32'hffff_ffff);
        bus(`SCI_REG_STATE, 1'b0, 32'h0);
        st = $urandom;
        bus(`SCI_REG_SET, 1'b1, st);
        repeat (1000) @(posedge clk_sys);
        bus(`SCI_REG_STATE, 1'b0, st);
        bus(`SCI_REG_QUICK_EN, 1'b1, 32'h00ff_0000);
        for (int op = 1; op < 4; op++) begin
            bus(`SCI_REG_QUICK_CMD, 1'b1, {25'h0, op[1:0], 5'd17});
            st[17] = (op != 2);
            bus(`SCI_REG_STATE, 1'b0, st);
        end
        // a disabled input must ignore whichever op would change it
        bus(`SCI_REG_QUICK_CMD, 1'b1, {25'h0, st[30] ? `SCI_QC_OP_RESET : `SCI_QC_OP_SET, 5'd30});
        bus(`SCI_REG_STATE, 1'b0, st);
        power(1'b1);
        bus(`SCI_REG_STATE, 1'b0, st & 32'hffff_0000);
        power(1'b0);
        bus(`SCI_REG_STATE, 1'b0, 32'h0);
        test_done;
    end
endmodule // test_sci_command_bank
